/* rtl/asrc_host.sv */
// Host controller driving an asynchronous 1K x 4 static memory
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defines.svh"
// Notes on behaviour
// - Host holds word index stable across the whole write cycle.
// - Host keeps strobe or select high whenever the word index changes.
// - Select may be held low permanently in a single-device system; the host still raises select after every cycle.
// - Early write: strobe falls before select, so select times the write.
module asrc_host (
   // Clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    reset_n_i,
   // User request
   input  wire logic                    req_valid_i,
   input  wire logic                    req_write_i,
   input  wire logic [`ASRC_ADDR_W-1:0] req_addr_i,
   input  wire logic [`ASRC_DATA_W-1:0] req_wdata_i,
   output logic                         req_ready_o,
   // User answer
   output logic                         rsp_valid_o,
   output logic [`ASRC_DATA_W-1:0]      rsp_rdata_o,
   // Memory pins
   output logic [`ASRC_ADDR_W-1:0]      word_index_lines_o,
   output logic                         select_n_o,
   output logic                         write_n_o,
   output logic [`ASRC_DATA_W-1:0]      shared_data_lines_o,
   output logic                         shared_data_lines_oe_o,
   input  wire logic [`ASRC_DATA_W-1:0] shared_data_lines_i
);
   asrc_timer_if       tif ();
   asrc_pkg::asrc_state_t state;
   asrc_pkg::asrc_state_t next_state;
   logic               is_write;
   logic               next_select_n;
   logic               next_write_n;
   logic               next_oe;
   logic               take_rdata;

   asrc_timer u_timer (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .tif       (tif.tmr)
   );

   function automatic logic [`ASRC_CNT_W-1:0] phase_len(
      input asrc_pkg::asrc_state_t st,
      input logic                  wr
   );
      logic [`ASRC_CNT_W-1:0] n;
      n = `ASRC_CNT_W'(1);
      case (st)
         asrc_pkg::ASRC_STROBE:
            n = wr ? `ASRC_CNT_W'(`ASRC_CYC_WPULSE - 1)
                   : `ASRC_CNT_W'(`ASRC_CYC_ACCESS - 1);
         asrc_pkg::ASRC_HOLD:
            n = `ASRC_CNT_W'(`ASRC_CYC_AHOLD - 1);
         asrc_pkg::ASRC_RECOVER:
            n = `ASRC_CNT_W'(`ASRC_CYC_CYCLE - `ASRC_CYC_WPULSE
                             - `ASRC_CYC_AHOLD - 1);
         default:
            n = `ASRC_CNT_W'(0);
      endcase
      return n;
   endfunction

   always_comb begin
      next_state = state;
      case (state)
         asrc_pkg::ASRC_IDLE:
            if (req_valid_i) begin
               next_state = asrc_pkg::ASRC_SETUP;
            end
         asrc_pkg::ASRC_SETUP:
            next_state = asrc_pkg::ASRC_STROBE;
         asrc_pkg::ASRC_STROBE:
            if (tif.done) begin
               next_state = asrc_pkg::ASRC_HOLD;
            end
         asrc_pkg::ASRC_HOLD:
            if (tif.done) begin
               next_state = asrc_pkg::ASRC_RECOVER;
            end
         asrc_pkg::ASRC_RECOVER:
            if (tif.done) begin
               next_state = asrc_pkg::ASRC_IDLE;
            end
         default:
            next_state = asrc_pkg::ASRC_IDLE;
      endcase
   end

   // Timer is reloaded on every phase change
   assign tif.load  = (next_state != state);
   assign tif.count = phase_len(next_state, is_write);

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= asrc_pkg::ASRC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Request capture; index and data stay put for the whole cycle
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         is_write            <= 1'b0;
         word_index_lines_o  <= '0;
         shared_data_lines_o <= '0;
      end else if (state == asrc_pkg::ASRC_IDLE && req_valid_i) begin
         is_write            <= req_write_i;
         word_index_lines_o  <= req_addr_i;
         shared_data_lines_o <= req_wdata_i;
      end
   end

   // Direction of the cycle being started or already running
   function automatic logic is_write_next();
      return (state == asrc_pkg::ASRC_IDLE) ? req_write_i : is_write;
   endfunction

   // Phases across which a write keeps its word on the data lines
   function automatic logic in_write_span(
      input asrc_pkg::asrc_state_t st
   );
      return (st == asrc_pkg::ASRC_SETUP)  ||
             (st == asrc_pkg::ASRC_STROBE) ||
             (st == asrc_pkg::ASRC_HOLD);
   endfunction

   // Strobes: write strobe leads, select times the stored word
   always_comb begin
      next_select_n = 1'b1;
      next_write_n  = 1'b1;
      case (next_state)
         asrc_pkg::ASRC_SETUP: begin
            next_select_n = 1'b1;
            next_write_n  = !is_write_next();
         end
         asrc_pkg::ASRC_STROBE: begin
            next_select_n = 1'b0;
            next_write_n  = write_n_o;
         end
         asrc_pkg::ASRC_HOLD: begin
            next_select_n = 1'b1;
            next_write_n  = write_n_o;
         end
         default: begin
            next_select_n = 1'b1;
            next_write_n  = 1'b1;
         end
      endcase
   end

   // Select frames every cycle and is never tied low
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         select_n_o <= 1'b1;
      end else begin
         select_n_o <= next_select_n;
      end
   end

   // Write strobe stays low from setup through the address hold
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         write_n_o <= 1'b1;
      end else begin
         write_n_o <= next_write_n;
      end
   end

   // Drive data lines only across a write; released before any read
   always_comb begin
      next_oe = is_write_next() && in_write_span(next_state);
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shared_data_lines_oe_o <= 1'b0;
      end else begin
         shared_data_lines_oe_o <= next_oe;
      end
   end

   // Read word taken at the end of the access time, same polarity
   assign take_rdata = (state == asrc_pkg::ASRC_STROBE) && tif.done &&
                       !is_write;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rsp_valid_o <= 1'b0;
      end else begin
         rsp_valid_o <= take_rdata;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rsp_rdata_o <= '0;
      end else if (take_rdata) begin
         rsp_rdata_o <= shared_data_lines_i;
      end
   end

   // Ready only while the sequencer rests in idle
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         req_ready_o <= 1'b0;
      end else begin
         req_ready_o <= (next_state == asrc_pkg::ASRC_IDLE);
      end
   end
endmodule // asrc_host
`default_nettype wire

/* rtl/asrc_defines.svh */
// Timing counts and field widths for the static memory host controller
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
`define ASRC_ADDR_W        10
`define ASRC_DATA_W        4
`define ASRC_CLK_PERIOD_NS 5
// Slowest grade figures, in ns, used so any grade is met
`define ASRC_T_CYCLE_NS    450
`define ASRC_T_WPULSE_NS   200
`define ASRC_T_ADDR_HOLD_NS 20
`define ASRC_T_ACCESS_NS   450
`define ASRC_CYC_CYCLE \
   ((`ASRC_T_CYCLE_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CYC_WPULSE \
   ((`ASRC_T_WPULSE_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CYC_AHOLD \
   ((`ASRC_T_ADDR_HOLD_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CYC_ACCESS \
   ((`ASRC_T_ACCESS_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CNT_W      8
`endif

/* rtl/asrc_pkg.sv */
// Types for the static memory host controller
package asrc_pkg;
   typedef enum logic [2:0] {
      ASRC_IDLE,
      ASRC_SETUP,
      ASRC_STROBE,
      ASRC_HOLD,
      ASRC_RECOVER
   } asrc_state_t;
endpackage

/* rtl/asrc_timer_if.sv */
// Interface between the sequencer and its cycle timer
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defines.svh"
interface asrc_timer_if;
   logic                    load;
   logic [`ASRC_CNT_W-1:0]  count;
   logic                    done;
   modport ctrl (output load, output count, input done);
   modport tmr  (input load, input count, output done);
endinterface
`default_nettype wire

/* rtl/asrc_timer.sv */
// Down counter that times the strobe, hold and recovery phases of a memory cycle
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defines.svh"
module asrc_timer (
   // Clock and reset
   input  wire logic   mclk_i,
   input  wire logic   reset_n_i,
   // Timer control
   asrc_timer_if.tmr   tif
);
   logic [`ASRC_CNT_W-1:0] remain;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         remain <= '0;
      end else if (tif.load) begin
         remain <= tif.count;
      end else if (remain != '0) begin
         remain <= remain - 1'b1;
      end
   end

   // Done looks at the count only; load is itself derived from done
   assign tif.done = (remain == '0);
endmodule // asrc_timer
`default_nettype wire

/* tb/asrc_sram_model.sv */
// Behavioural 1K x 4 static memory at the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model (
   input  wire logic [9:0] addr_i,
   input  wire logic       sel_n_i,
   input  wire logic       we_n_i,
   input  wire logic [3:0] dq_i,
   input  wire logic       host_oe_i,
   output logic [3:0]      dq_o,
   output logic            clash_o
);
   logic [3:0] mem [0:1023];
   logic [3:0] last = 4'h0;
   logic       drive;
   initial clash_o = 1'b0;
   // Drives only while selected in read mode, never during a write
   assign drive = !sel_n_i && we_n_i;
   // Store only while both strobes are low, no clock involved
   always @* if (!sel_n_i && !we_n_i) mem[addr_i] = dq_i;
   always @* if (drive) last = mem[addr_i];
   // Released lines show the inverse of the last word, never a stale copy
   assign dq_o = drive ? mem[addr_i] : ~last;
   // Both ends driving the data lines at once
   always @* if (drive && host_oe_i) clash_o = 1'b1;
endmodule // asrc_sram_model
`default_nettype wire

/* tb/asrc_host_monitor.sv */
// Pin protocol checker for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defines.svh"
module asrc_host_monitor (
   input wire logic                    mclk_i,
   input wire logic                    reset_n_i,
   input wire logic                    req_valid_i,
   input wire logic                    req_write_i,
   input wire logic                    req_ready_o,
   input wire logic                    rsp_valid_o,
   input wire logic [`ASRC_ADDR_W-1:0] word_index_lines_o,
   input wire logic                    select_n_o,
   input wire logic                    write_n_o,
   input wire logic [`ASRC_DATA_W-1:0] shared_data_lines_o,
   input wire logic                    shared_data_lines_oe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   oe_write_a: assert property (
      shared_data_lines_oe_o |-> !write_n_o)
      else $error("data driven outside a write");
   addr_guard_a: assert property (
      !$stable(word_index_lines_o) |-> write_n_o || select_n_o)
      else $error("address moved while writing");
   addr_hold_a: assert property (
      !select_n_o && !write_n_o |-> $stable(word_index_lines_o))
      else $error("address unstable in write");
   data_hold_a: assert property (
      !select_n_o && !write_n_o |->
      shared_data_lines_oe_o && $stable(shared_data_lines_o))
      else $error("write data not held");
   early_write_a: assert property (
      $fell(select_n_o) && !write_n_o |-> !$past(write_n_o))
      else $error("strobe not ahead of select");
   wr_pulse_a: assert property (
      $fell(select_n_o) && !write_n_o |-> ##[38:42] $rose(select_n_o))
      else $error("write pulse length");
   rd_time_a: assert property (
      req_ready_o && req_valid_i && !req_write_i |->
      ##[89:93] rsp_valid_o) else $error("read answer late");
   rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
      else $error("answer longer than one cycle");
   rsp_read_a: assert property (
      rsp_valid_o |-> write_n_o && !shared_data_lines_oe_o)
      else $error("answer outside a read");
   strobe_end_a: assert property (
      $rose(write_n_o) |-> select_n_o && !shared_data_lines_oe_o)
      else $error("strobe released early");
endmodule // asrc_host_monitor
bind asrc_host asrc_host_monitor MON (.*);
`default_nettype wire

/* tb/asrc_host_bench.sv */
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module asrc_host_bench;
   logic mclk_i = 0, reset_n_i = 0, req_valid_i = 0, req_write_i = 0;
   logic [9:0] req_addr_i = 10'h000, word_index_lines_o, wa [6];
   logic [3:0] req_wdata_i = 4'h0, rsp_rdata_o, shared_data_lines_o;
   logic [3:0] shared_data_lines_i, mdl, ref_m [0:1023], expq [$];
   logic req_ready_o, rsp_valid_o, select_n_o, write_n_o;
   logic shared_data_lines_oe_o, clash;
   int mismatches = 0, tests_run = 0, cyc = 0;
   always #2.5 mclk_i = ~mclk_i;
   asrc_host DUT (.*);
   asrc_sram_model MEM (.addr_i(word_index_lines_o), .sel_n_i(select_n_o),
      .we_n_i(write_n_o), .dq_i(shared_data_lines_i), .dq_o(mdl),
      .host_oe_i(shared_data_lines_oe_o),
      .clash_o(clash));
   assign shared_data_lines_i = shared_data_lines_oe_o ?
      shared_data_lines_o : mdl;
   task chk(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Held until the edge that samples ready high, released just after it
   task op(input logic w, input logic [9:0] a, input logic [3:0] d);
      {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, w, a, d};
      if (w) ref_m[a] = d;
      else expq.push_back(ref_m[a]);
      do @(negedge mclk_i); while (req_ready_o !== 1'b1);
      @(posedge mclk_i);
      #1 req_valid_i = 0;
      @(posedge mclk_i);
      #1;
   endtask
   always @(negedge mclk_i) if (rsp_valid_o === 1'b1) begin
      if (expq.size() == 0) chk(rsp_rdata_o, 4'hX);
      else chk(rsp_rdata_o, expq.pop_front());
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         end_sim;
      end
   end
   initial begin
      void'($urandom(3594));
      repeat (8) @(posedge mclk_i);
      #1 chk({select_n_o, write_n_o, 2'h0}, 4'hC);
      chk({3'h0, shared_data_lines_oe_o}, 4'h0);
      reset_n_i = 1;
      @(posedge mclk_i);
      #1;
      for (int i = 0; i < 6; i++) begin
         wa[i] = i == 0 ? 10'h000 : i == 1 ? 10'h3FF
               : 10'($urandom_range(2, 1021));
         op(1'b1, wa[i], 4'($urandom));
      end
      op(1'b1, 10'h3FE, ~ref_m[10'h3FF]);
      for (int i = 5; i >= 0; i--) op(1'b0, wa[i], 4'h0);
      // A write offered while busy must be dropped
      op(1'b1, 10'h155, 4'h5);
      {req_valid_i, req_write_i, req_addr_i, req_wdata_i} =
         {1'b1, 1'b1, 10'h155, 4'hA};
      repeat (20) @(posedge mclk_i);
      #1 req_valid_i = 0;
      op(1'b0, 10'h155, 4'h0);
      op(1'b0, 10'h3FE, 4'h0);
      repeat (250) @(posedge mclk_i);
      chk(4'(expq.size()), 4'h0);
      chk({3'h0, clash}, 4'h0);
      end_sim;
   end
endmodule // asrc_host_bench
`default_nettype wire
